// >>> src/ptmr_pkg.sv
package ptmr_pkg;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 12;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [9:0] CNT_RST = 10'h000;
    localparam logic [9:0] CNT_MAX = 10'h3FF;

    // Byte address of each register; every register takes one aligned word.
    localparam logic [11:0] OFS_RUN_CONTROL = 12'h000;
    localparam logic [11:0] OFS_MODE_OUT = 12'h004;
    localparam logic [11:0] OFS_CAP_CLR = 12'h008;
    localparam logic [11:0] OFS_CNT_LO = 12'h00C;
    localparam logic [11:0] OFS_CNT_HI = 12'h010;
    localparam logic [11:0] OFS_CA_LO = 12'h014;
    localparam logic [11:0] OFS_CA_HI = 12'h018;
    localparam logic [11:0] OFS_CB_LO = 12'h01C;
    localparam logic [11:0] OFS_CB_HI = 12'h020;
    localparam logic [11:0] OFS_PER_LO = 12'h024;
    localparam logic [11:0] OFS_PER_HI = 12'h028;
    localparam logic [11:0] OFS_EVENTS = 12'h02C;

    // Field positions.
    localparam int RUN_ON_BIT = 3;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int PINF_HI = 5;
    localparam int PINF_LO = 4;
    localparam int INIT_BIT = 3;
    localparam int INV_BIT = 2;
    localparam int CAPSRC_BIT = 1;
    localparam int CCLR_BIT = 0;
    localparam int CAPCLR_HI = 2;
    localparam int CAPCLR_LO = 1;
    localparam int EDGE_BIT = 0;
    localparam int EV_MATCH_A_BIT = 0;
    localparam int EV_PERIOD_BIT = 1;
    localparam int EV_CAPTURE_BIT = 2;

    // Mode field and pin function codes.
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    localparam logic [1:0] PINF_0 = 2'h0;
    localparam logic [1:0] PINF_1 = 2'h1;
    localparam logic [1:0] PINF_2 = 2'h2;
    localparam logic [1:0] PINF_3 = 2'h3;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } ptmr_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ptmr_apb_rsp_s;
endpackage

// >>> src/ptmr_periodic_timer.sv
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
// Behaviour
// - On rise clears counter; off freezes it
// - On rise restores output initial level in compare and PWM modes
// - Mode field selects compare, capture, PWM, timer
// - Match A applies none, low, high, toggle
// - PWM pin field: inactive, active, PWM, pulse
// - Capture edges latch into compare A or B
// - Capture source: input pin or clock pin
// - Capture clear field selects counter clear edges
// - Edge flag shows edge of last latch
// - Initial level sets start or active level
// - Invert bit flips output except timer mode
// - Clear select: match A or period/overflow
// - Clear select ignored in PWM and capture
// - Match requesting initial level leaves output alone
// - Counter readable as low and high bytes
// - Compare A read/write split, resets zero
// - Compare B read/write split, resets zero
// - Timer mode leaves pin field unused
// - Ten-bit up-counter with A and period comparators
// - Separate match A and period flags
module ptmr_periodic_timer (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic arst_n_i,
    // APB slave.
    input ptmr_pkg::ptmr_apb_req_s apb_req_i,
    output ptmr_pkg::ptmr_apb_rsp_s apb_rsp_o,
    // Timer pins.
    input wire logic capture_input_pin_i,
    input wire logic external_clock_pin_i,
    output logic timer_output_pin_o
);
    import ptmr_pkg::*;

    function automatic logic period_hit(input logic [9:0] cnt, input logic [9:0] per);
        // A zero period lets the counter run to its top value and overflow.
        period_hit = (per == CNT_RST) ? (cnt == CNT_MAX) : (cnt == per);
    endfunction

    function automatic logic drives_output(input logic [1:0] mode);
        drives_output = (mode == MODE_CMP) || (mode == MODE_PWM);
    endfunction

    logic on_reg;
    logic on_q_reg;
    logic [7:0] mode_out_reg;
    logic [1:0] cap_clr_reg;
    logic edge_flag_reg;
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic [9:0] ca_reg;
    logic [9:0] cb_reg;
    logic [9:0] per_reg;
    logic [2:0] events_reg;
    logic trig_q_reg;
    logic level_reg;
    logic level_next;
    logic pulse_reg;
    logic pin_reg;
    ptmr_apb_rsp_s rsp_reg;

    logic [1:0] mode;
    logic [1:0] pinf;
    logic init_lvl;
    logic on_rise;
    logic running;
    logic match_a;
    logic match_p;
    logic trig;
    logic trig_rise;
    logic trig_fall;
    logic cap_rise_act;
    logic cap_fall_act;
    logic cap_to_a;
    logic cap_to_b;
    logic cap_event;
    logic cnt_clear;
    logic ev_match_a;
    logic ev_period;
    logic setup_ph;
    logic wr_en;
    logic mapped;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    assign mode = mode_out_reg[MODE_HI:MODE_LO];
    assign pinf = mode_out_reg[PINF_HI:PINF_LO];
    assign init_lvl = mode_out_reg[INIT_BIT];
    assign on_rise = on_reg && !on_q_reg;
    assign running = on_reg && on_q_reg;
    // A zero compare A value never matches; the counter then overflows instead.
    assign match_a = running && (ca_reg != CNT_RST) && (cnt_reg == ca_reg);
    assign match_p = running && period_hit(cnt_reg, per_reg);
    assign trig = mode_out_reg[CAPSRC_BIT] ? external_clock_pin_i : capture_input_pin_i;
    assign trig_rise = running && trig && !trig_q_reg;
    assign trig_fall = running && !trig && trig_q_reg;

    // Active capture edges chosen by the pin function field in capture mode.
    always_comb begin
        cap_rise_act = 1'b0;
        cap_fall_act = 1'b0;
        if (mode == MODE_CAP) begin
            case (pinf)
                PINF_0: cap_rise_act = trig_rise;
                PINF_1: cap_fall_act = trig_fall;
                PINF_2: begin
                    cap_rise_act = trig_rise;
                    cap_fall_act = trig_fall;
                end
                default: begin
                    cap_rise_act = 1'b0;
                    cap_fall_act = 1'b0;
                end
            endcase
        end
    end

    assign cap_to_a = (cap_clr_reg == 2'h0) ? (cap_rise_act || cap_fall_act)
        : cap_fall_act;
    assign cap_to_b = (cap_clr_reg != 2'h0) && cap_rise_act;
    assign cap_event = cap_to_a || cap_to_b;

    // Counter clear source per mode.
    always_comb begin
        case (mode)
            MODE_CMP, MODE_TMR: cnt_clear = mode_out_reg[CCLR_BIT] ? match_a : match_p;
            MODE_PWM: cnt_clear = match_p;
            MODE_CAP: cnt_clear = match_p
                || (cap_clr_reg[0] && trig_rise)
                || (cap_clr_reg[1] && trig_fall);
            default: cnt_clear = match_p;
        endcase
    end

    always_comb begin
        if (on_rise) begin
            cnt_next = CNT_RST;
        end else if (!on_reg) begin
            cnt_next = cnt_reg;
        end else if (cnt_clear) begin
            cnt_next = CNT_RST;
        end else begin
            cnt_next = cnt_reg + 10'h001;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= CNT_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            on_q_reg <= 1'b0;
            trig_q_reg <= 1'b0;
        end else begin
            on_q_reg <= on_reg;
            trig_q_reg <= trig;
        end
    end

    assign ev_match_a = match_a && (mode != MODE_CAP);
    assign ev_period = match_p && !((mode == MODE_CMP || mode == MODE_TMR)
        && mode_out_reg[CCLR_BIT]);

    // Output level before inversion.
    always_comb begin
        level_next = level_reg;
        if (on_rise && drives_output(mode)) begin
            level_next = init_lvl;
        end else if (mode == MODE_CMP) begin
            if (match_a) begin
                case (pinf)
                    PINF_1: level_next = init_lvl ? 1'b0 : level_reg;
                    PINF_2: level_next = init_lvl ? level_reg : 1'b1;
                    PINF_3: level_next = !level_reg;
                    default: level_next = level_reg;
                endcase
            end
        end else if (mode == MODE_PWM && on_reg) begin
            case (pinf)
                PINF_0: level_next = !init_lvl;
                PINF_1: level_next = init_lvl;
                PINF_2: level_next = (cnt_reg < ca_reg) ? init_lvl : !init_lvl;
                default: level_next = pulse_reg ? init_lvl : !init_lvl;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_reg <= 1'b0;
            pulse_reg <= 1'b0;
            pin_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
            if (on_rise) begin
                pulse_reg <= 1'b1;
            end else if (match_a || !on_reg) begin
                pulse_reg <= 1'b0;
            end
            if (mode == MODE_TMR) begin
                pin_reg <= 1'b0;
            end else begin
                pin_reg <= level_next ^ mode_out_reg[INV_BIT];
            end
        end
    end

    // APB: the answer is prepared in the setup cycle and offered in the access phase.
    assign setup_ph = apb_req_i.psel && !apb_req_i.penable;
    assign wr_en = apb_req_i.psel && apb_req_i.penable && rsp_reg.pready
        && apb_req_i.pwrite && !rsp_reg.pslverr;
    assign wbyte = apb_req_i.pwdata[7:0];

    always_comb begin
        mapped = 1'b1;
        rd_byte = BYTE_RST;
        case (apb_req_i.paddr)
            OFS_RUN_CONTROL: rd_byte[RUN_ON_BIT] = on_reg;
            OFS_MODE_OUT: rd_byte = mode_out_reg;
            OFS_CAP_CLR: rd_byte[2:0] = {cap_clr_reg, edge_flag_reg};
            OFS_CNT_LO: rd_byte = cnt_reg[7:0];
            OFS_CNT_HI: rd_byte[1:0] = cnt_reg[9:8];
            OFS_CA_LO: rd_byte = ca_reg[7:0];
            OFS_CA_HI: rd_byte[1:0] = ca_reg[9:8];
            OFS_CB_LO: rd_byte = cb_reg[7:0];
            OFS_CB_HI: rd_byte[1:0] = cb_reg[9:8];
            OFS_PER_LO: rd_byte = per_reg[7:0];
            OFS_PER_HI: rd_byte[1:0] = per_reg[9:8];
            OFS_EVENTS: rd_byte[2:0] = events_reg;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_reg <= '0;
        end else if (setup_ph) begin
            rsp_reg.pready <= 1'b1;
            rsp_reg.pslverr <= !mapped;
            rsp_reg.prdata <= {24'h000000, rd_byte};
        end else if (rsp_reg.pready) begin
            rsp_reg <= '0;
        end
    end

    // Control registers written by software.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            on_reg <= 1'b0;
            mode_out_reg <= BYTE_RST;
            cap_clr_reg <= 2'h0;
            per_reg <= CNT_RST;
        end else if (wr_en) begin
            case (apb_req_i.paddr)
                OFS_RUN_CONTROL: on_reg <= wbyte[RUN_ON_BIT];
                OFS_MODE_OUT: mode_out_reg <= wbyte;
                OFS_CAP_CLR: cap_clr_reg <= wbyte[CAPCLR_HI:CAPCLR_LO];
                OFS_PER_LO: per_reg[7:0] <= wbyte;
                OFS_PER_HI: per_reg[9:8] <= wbyte[1:0];
                default: on_reg <= on_reg;
            endcase
        end
    end

    // Compare registers; a hardware capture wins over a software write in the same cycle.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ca_reg <= CNT_RST;
            cb_reg <= CNT_RST;
        end else begin
            if (cap_to_a) begin
                ca_reg <= cnt_reg;
            end else if (wr_en && apb_req_i.paddr == OFS_CA_LO) begin
                ca_reg[7:0] <= wbyte;
            end else if (wr_en && apb_req_i.paddr == OFS_CA_HI) begin
                ca_reg[9:8] <= wbyte[1:0];
            end
            if (cap_to_b) begin
                cb_reg <= cnt_reg;
            end else if (wr_en && apb_req_i.paddr == OFS_CB_LO) begin
                cb_reg[7:0] <= wbyte;
            end else if (wr_en && apb_req_i.paddr == OFS_CB_HI) begin
                cb_reg[9:8] <= wbyte[1:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            edge_flag_reg <= 1'b0;
        end else if (cap_event) begin
            edge_flag_reg <= cap_rise_act;
        end
    end

    // Event flags clear by writing one; a new event in the same cycle wins.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            events_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_en && apb_req_i.paddr == OFS_EVENTS && wbyte[i]) begin
                    events_reg[i] <= 1'b0;
                end
            end
            if (ev_match_a) begin
                events_reg[EV_MATCH_A_BIT] <= 1'b1;
            end
            if (ev_period) begin
                events_reg[EV_PERIOD_BIT] <= 1'b1;
            end
            if (cap_event) begin
                events_reg[EV_CAPTURE_BIT] <= 1'b1;
            end
        end
    end

    assign apb_rsp_o = rsp_reg;
    assign timer_output_pin_o = pin_reg;

    chk_on_rise_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        on_rise |=> cnt_reg == CNT_RST) else $error("counter not cleared on start");
    chk_off_freeze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !on_reg && !on_q_reg |=> $stable(cnt_reg)) else $error("stopped counter moved");
    chk_start_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        on_rise && drives_output(mode) |=> level_reg == $past(init_lvl))
        else $error("output not at initial level after start");
    chk_cmp_toggle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        mode == MODE_CMP && match_a && pinf == PINF_3 && !on_rise
        |=> level_reg != $past(level_reg)) else $error("toggle on match missing");
    chk_capture_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cap_to_a |=> ca_reg == $past(cnt_reg)) else $error("capture into A wrong");
    chk_capture_b: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cap_to_b |=> cb_reg == $past(cnt_reg) && edge_flag_reg)
        else $error("capture into B wrong");
    chk_cap_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        mode == MODE_CAP && cap_clr_reg[0] && trig_rise |=> cnt_reg == CNT_RST)
        else $error("rising edge did not clear counter");
    chk_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        mode == MODE_CMP && mode_out_reg[CCLR_BIT] && match_a |=> cnt_reg == CNT_RST)
        else $error("match A did not clear counter");
    chk_timer_pin: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        mode == MODE_TMR |=> timer_output_pin_o == 1'b0)
        else $error("timer mode drives pin");
    chk_cap_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cap_event |=> events_reg[EV_CAPTURE_BIT]) else $error("capture flag not set");
endmodule // ptmr_periodic_timer

// >>> tb/ptmr_pin_model.sv
`timescale 1ns/10ps
module ptmr_pin_model (
    // Clock.
    input wire logic clk_i,
    // Bench control.
    input wire logic src_sel_i,
    input wire logic level_i,
    input wire logic cnt_clr_i,
    // Timer pins.
    input wire logic timer_output_pin_i,
    output logic capture_input_pin_o,
    output logic external_clock_pin_o,
    output logic [7:0] high_cnt_o
);
    initial begin
        capture_input_pin_o = 1'b0;
        external_clock_pin_o = 1'b0;
        high_cnt_o = 8'h00;
    end
    // Only the selected pin follows the level, so the other one proves it is ignored.
    always @(posedge clk_i) begin
        if (src_sel_i) begin
            external_clock_pin_o <= level_i;
        end else begin
            capture_input_pin_o <= level_i;
        end
    end
    // Counts cycles with the timer output high, to measure duty.
    always @(posedge clk_i) begin
        if (cnt_clr_i) begin
            high_cnt_o <= 8'h00;
        end else begin
            high_cnt_o <= high_cnt_o + {7'h00, timer_output_pin_i};
        end
    end
endmodule // ptmr_pin_model

// >>> tb/ptmr_periodic_timer_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ptmr_periodic_timer_tb;
    import ptmr_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    ptmr_apb_req_s req = '0;
    ptmr_apb_rsp_s rsp;
    logic src_sel = 1'b0;
    logic level = 1'b0;
    logic cnt_clr = 1'b0;
    logic cap_pin;
    logic ext_pin;
    logic out_pin;
    logic [7:0] high_cnt;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int n_checks = 0;
    always #2 clk_i = ~clk_i;
    ptmr_periodic_timer ptmr_periodic_timer_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .apb_req_i(req), .apb_rsp_o(rsp), .capture_input_pin_i(cap_pin),
        .external_clock_pin_i(ext_pin), .timer_output_pin_o(out_pin));
    ptmr_pin_model ptmr_pin_model_i (.clk_i(clk_i), .src_sel_i(src_sel), .level_i(level),
        .cnt_clr_i(cnt_clr), .timer_output_pin_i(out_pin), .capture_input_pin_o(cap_pin),
        .external_clock_pin_o(ext_pin), .high_cnt_o(high_cnt));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Setup, then access held until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h000000, d}};
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (rsp.pready !== 1'b1 && k < 8);
        if (k >= 8) begin
            miscompares++;
            finish_test();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(nm, {24'h000000, e}, rd)
    endtask
    task automatic run(input logic v);
        apb(1'b1, OFS_RUN_CONTROL, {4'h0, v, 3'h0});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic setv(input logic [11:0] a, input logic [9:0] v);
        apb(1'b1, a, v[7:0]);
        apb(1'b1, a + 12'h004, {6'h00, v[9:8]});
    endtask

    task automatic t_regs();
        logic [11:0] ad[7];
        ad = '{OFS_MODE_OUT, OFS_CAP_CLR, OFS_CNT_LO, OFS_CNT_HI, OFS_CA_LO, OFS_CA_HI, OFS_CB_LO};
        foreach (ad[i]) rchk("reset value", ad[i], 8'h00);
        apb(1'b0, 12'h030, 8'h00);
        `CHK("unmapped error", 1'b1, err)
        apb(1'b1, OFS_CA_HI, 8'hFF);
        rchk("ca hi", OFS_CA_HI, 8'h03);
        apb(1'b1, OFS_CB_LO, 8'h5A);
        rchk("cb lo", OFS_CB_LO, 8'h5A);
        apb(1'b1, OFS_CNT_LO, 8'h77);
        rchk("count ro", OFS_CNT_LO, 8'h00);
        apb(1'b1, OFS_CAP_CLR, 8'h07);
        rchk("edge flag ro", OFS_CAP_CLR, 8'h06);
        apb(1'b1, OFS_CAP_CLR, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_count();
        logic [7:0] v1;
        setv(OFS_CA_LO, 10'h000);
        setv(OFS_PER_LO, 10'h000);
        apb(1'b1, OFS_MODE_OUT, {MODE_TMR, PINF_3, 4'hC});
        run(1'b1);
        apb(1'b0, OFS_CNT_LO, 8'h00);
        v1 = rd[7:0];
        apb(1'b0, OFS_CNT_LO, 8'h00);
        `CHK("count step", 8'h03, rd[7:0] - v1)
        `CHK("timer mode pin", 1'b0, out_pin)
        run(1'b0);
        apb(1'b0, OFS_CNT_LO, 8'h00);
        v1 = rd[7:0];
        wt(10);
        rchk("count held", OFS_CNT_LO, v1);
        run(1'b1);
        apb(1'b0, OFS_CNT_LO, 8'h00);
        `CHK("count cleared", 8'h00, rd[7:0])
        run(1'b0);
        $display("test count done");
    endtask
    task automatic t_flags();
        setv(OFS_CA_LO, 10'h00A);
        setv(OFS_PER_LO, 10'h005);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, OFS_MODE_OUT, {MODE_CMP, PINF_0, 3'h0, s[0]});
            apb(1'b1, OFS_EVENTS, 8'h07);
            run(1'b1);
            wt(60);
            run(1'b0);
            rchk("match flags", OFS_EVENTS, s ? 8'h01 : 8'h02);
            apb(1'b0, OFS_CNT_LO, 8'h00);
            `CHK("clear point", 1'b1, rd[7:0] <= (s ? 8'h0A : 8'h05))
        end
        apb(1'b1, OFS_EVENTS, 8'h07);
        rchk("flags cleared", OFS_EVENTS, 8'h00);
        $display("test flags done");
    endtask
    task automatic t_cmp();
        logic [1:0] pf;
        logic il;
        logic inv;
        logic e;
        setv(OFS_CA_LO, 10'h014);
        setv(OFS_PER_LO, 10'h000);
        for (int c = 0; c < 16; c++) begin
            pf = c[1:0];
            il = c[2];
            inv = c[3];
            run(1'b0);
            apb(1'b1, OFS_MODE_OUT, {MODE_CMP, pf, il, inv, 2'b01});
            run(1'b1);
            wt(4);
            `CHK("initial level", il ^ inv, out_pin)
            wt(26);
            e = (pf == PINF_0) ? il : (pf == PINF_1) ? 1'b0 : (pf == PINF_2) ? 1'b1 : ~il;
            `CHK("match output", e ^ inv, out_pin)
        end
        run(1'b0);
        $display("test cmp done");
    endtask
    task automatic t_pwm();
        setv(OFS_CA_LO, 10'h004);
        setv(OFS_PER_LO, 10'h00A);
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, OFS_MODE_OUT, {MODE_PWM, c[1:0], 4'h9});
            run(1'b1);
            wt(5);
            `CHK("forced level", c[0], out_pin)
            run(1'b0);
        end
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, OFS_MODE_OUT, {MODE_PWM, PINF_2, 1'b1, inv[0], 2'b01});
            run(1'b1);
            wt(20);
            @(posedge clk_i);
            cnt_clr <= 1'b1;
            @(posedge clk_i);
            cnt_clr <= 1'b0;
            wt(22);
            `CHK("pwm duty", inv ? 8'h0E : 8'h08, high_cnt)
            run(1'b0);
        end
        apb(1'b1, OFS_MODE_OUT, {MODE_PWM, PINF_3, 4'h8});
        run(1'b1);
        wt(2);
        `CHK("pulse start", 1'b1, out_pin)
        wt(30);
        `CHK("pulse end", 1'b0, out_pin)
        run(1'b0);
        $display("test pwm done");
    endtask
    task automatic edge_to(input logic v, input int n);
        @(posedge clk_i);
        level <= v;
        wt(n);
    endtask
    task automatic t_cap();
        setv(OFS_PER_LO, 10'h000);
        apb(1'b1, OFS_MODE_OUT, {MODE_CAP, PINF_2, 4'h0});
        apb(1'b1, OFS_CAP_CLR, 8'h02);
        run(1'b1);
        wt(100);
        apb(1'b1, OFS_EVENTS, 8'h07);
        edge_to(1'b1, 20);
        edge_to(1'b0, 5);
        rchk("edge falling", OFS_CAP_CLR, 8'h02);
        apb(1'b0, OFS_CA_LO, 8'h00);
        `CHK("ca latch", 1'b1, rd[7:0] >= 8'h13 && rd[7:0] <= 8'h15)
        apb(1'b0, OFS_CB_LO, 8'h00);
        `CHK("cb latch", 1'b1, rd[7:0] > 8'h32)
        rchk("capture flag", OFS_EVENTS, 8'h04);
        edge_to(1'b1, 5);
        rchk("edge rising", OFS_CAP_CLR, 8'h03);
        run(1'b0);
        apb(1'b1, OFS_MODE_OUT, {MODE_CAP, PINF_0, 4'h2});
        apb(1'b1, OFS_CAP_CLR, 8'h00);
        run(1'b1);
        apb(1'b1, OFS_EVENTS, 8'h07);
        edge_to(1'b0, 3);
        edge_to(1'b1, 5);
        rchk("other pin ignored", OFS_EVENTS, 8'h00);
        src_sel <= 1'b1;
        edge_to(1'b1, 3);
        rchk("clock pin capture", OFS_EVENTS, 8'h04);
        run(1'b0);
        apb(1'b1, OFS_MODE_OUT, {MODE_CAP, PINF_3, 4'h2});
        run(1'b1);
        apb(1'b1, OFS_EVENTS, 8'h07);
        edge_to(1'b0, 3);
        edge_to(1'b1, 5);
        rchk("capture disabled", OFS_EVENTS, 8'h00);
        run(1'b0);
        $display("test cap done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_count();
        t_flags();
        t_cmp();
        t_pwm();
        t_cap();
        finish_test();
    end
endmodule // ptmr_periodic_timer_tb
